// ===== hw/tpr_cfg.svh
// Constants for the three-port memory with optional error correction.
`ifndef TPR_CFG_SVH
`define TPR_CFG_SVH
`define TPR_ADDR_W 7
`define TPR_DATA_W 18
`define TPR_ROW_W 12
`define TPR_DEPTH 128
`define TPR_CODE_W 24
`define TPR_PAR_W 5
`define TPR_NARROW_W 9
`define TPR_SEL_ALL 2'h3
`define TPR_RESET_VAL 1'h0
`endif

// ===== hw/tpr_pkg.sv
// Types and check-code packing shared by the three-port memory files.
`include "tpr_cfg.svh"
`default_nettype none
package tpr_pkg;

  typedef struct packed {
    logic en;
    logic [1:0] sel;
    logic wide;
    logic [`TPR_ADDR_W-1:0] addr;
    logic [`TPR_DATA_W-1:0] data;
  } tpr_wr_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [`TPR_ADDR_W-1:0] addr;
    logic wide;
    logic areg_en;
    logic areg_sclr_n;
    logic areg_byp;
    logic pipe_en;
    logic pipe_sclr_n;
    logic pipe_byp;
  } tpr_rd_ctl_t;

  typedef struct packed {
    logic db;
    logic sb;
    logic [`TPR_DATA_W-1:0] data;
  } tpr_rd_res_t;

  // Hamming positions 1..23 carry data and parity; bit 0 is overall parity.
  function automatic logic [`TPR_CODE_W-1:0] tpr_ecc_pack(
      input logic [`TPR_DATA_W-1:0] d);
    logic [`TPR_CODE_W-1:0] c;
    int n;
    c = '0;
    n = 0;
    for (int j = 3; j < `TPR_CODE_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        c[j] = d[n];
        n++;
      end
    end
    for (int k = 0; k < `TPR_PAR_W; k++) begin
      for (int j = 1; j < `TPR_CODE_W; j++) begin
        if ((((j >> k) & 1) != 0) && (j != (1 << k))) begin
          c[1 << k] = c[1 << k] ^ c[j];
        end
      end
    end
    c[0] = ^c[`TPR_CODE_W-1:1];
    return c;
  endfunction

endpackage
`default_nettype wire

// ===== hw/tpr_stage.sv
// Bypassable register stage with enable, synchronous and asynchronous clear.
`include "tpr_cfg.svh"
`default_nettype none
module tpr_stage #(
  parameter int W = 8
) (
  // Clock and global clear
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic bypass,
  input wire logic en,
  input wire logic sclr_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] held;

  generate
    if (W < 1) begin : g_chk
      $error("tpr_stage width must be positive");
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      held <= '0;
    end else if (en) begin
      held <= sclr_n ? d : '0;  // R21
    end
  end

  assign q = bypass ? d : held;

endmodule
`default_nettype wire

// ===== hw/tpr_ecc_dec.sv
// Single-correct, double-detect decoder for one 24-bit stored code word.
`include "tpr_cfg.svh"
`default_nettype none
module tpr_ecc_dec (
  // Stored code word
  input wire logic [`TPR_CODE_W-1:0] code,
  // Decoded word and flags
  output logic [`TPR_DATA_W-1:0] data,
  output logic sb,
  output logic db
);

  logic [`TPR_PAR_W-1:0] syn;
  logic par;
  logic [`TPR_CODE_W-1:0] fixed;
  int n;

  always_comb begin
    syn = '0;
    fixed = code;
    data = '0;
    n = 0;
    for (int j = 1; j < `TPR_CODE_W; j++) begin
      for (int k = 0; k < `TPR_PAR_W; k++) begin
        if (((j >> k) & 1) != 0) begin
          syn[k] = syn[k] ^ code[j];
        end
      end
    end
    par = ^code;
    // A syndrome past the last position means more than one bit flipped.
    sb = par && (int'(syn) < `TPR_CODE_W);
    db = (syn != '0) && !sb;
    if (sb && (syn != '0)) begin
      fixed[syn] = ~code[syn];
    end
    for (int j = 3; j < `TPR_CODE_W; j++) begin
      if ((j & (j - 1)) != 0) begin
        data[n] = fixed[j];
        n++;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/tpr_mem.sv
// Three-port memory: one registered write port and two read ports.
// Behaviour
// R1: 1536 bits plain, 1152 with check bits.
// R2: Write inputs captured in registers each edge.
// R3: Read address register, enable, clear, bypass.
// R4: Read data register, enable, clear, bypass.
// R5: Four read timing modes per read port.
// R6: Check mode forces 64x18 on every port.
// R7: Ports 64x18 or 128x9; 128x12 all together.
// R8: All registered actions on rising clock edge.
// R9: Both read ports may read one location.
// R10: Read-write collision undefined; write still stored.
// R11: Per-port corrected and detected flags, active high.
// R12: Width select 0 deep, 1 wide.
// R13: Addresses MSB-justified; wide mode ignores bit 0.
// R14: Write data LSB-justified; unused upper bits zero.
// R15: Read data LSB-justified; unused bits zero.
// R16: Read needs both select bits; else zeros.
// R17: Write needs both select bits high.
// R18: Write inputs sampled at rising edge.
// R19: Write only while write enable is high.
// R20: Static configuration inputs tied at design time.
// R21: Stage clears async, passes bypassed, else loads while enabled.
// R22: Check pipeline adds one cycle unless bypassed.
// R23: Lock blocks config access; busy flags access.
// R24: Each enabled stage adds one cycle.
// R25: Flags travel with data through same stages.
`include "tpr_cfg.svh"
`default_nettype none
module tpr_mem #(
  parameter int ADDR_W = `TPR_ADDR_W,
  parameter int DATA_W = `TPR_DATA_W,
  parameter int ROW_W = `TPR_ROW_W
) (
  // Clock and global asynchronous clear of the read stages, write capture and access registers
  input wire logic clk_sys,
  input wire logic reset_n,
  // Write port
  input wire logic [`TPR_ADDR_W-1:0] wr_addr,
  input wire logic [`TPR_DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic wr_wide,
  // First read port
  input wire logic [`TPR_ADDR_W-1:0] rd_addr_first,
  input wire logic [1:0] rd_sel_first,
  input wire logic rd_wide_first,
  input wire logic rd_areg_en_first,
  input wire logic rd_areg_sclr_first_n,
  input wire logic rd_areg_bypass_first,
  input wire logic rd_pipe_en_first,
  input wire logic rd_pipe_sclr_first_n,
  input wire logic rd_pipe_bypass_first,
  output logic [`TPR_DATA_W-1:0] rd_data_first,
  output logic single_fix_flag_first,
  output logic double_err_flag_first,
  // Second read port
  input wire logic [`TPR_ADDR_W-1:0] rd_addr_second,
  input wire logic [1:0] rd_sel_second,
  input wire logic rd_wide_second,
  input wire logic rd_areg_en_second,
  input wire logic rd_areg_sclr_second_n,
  input wire logic rd_areg_bypass_second,
  input wire logic rd_pipe_en_second,
  input wire logic rd_pipe_sclr_second_n,
  input wire logic rd_pipe_bypass_second,
  output logic [`TPR_DATA_W-1:0] rd_data_second,
  output logic single_fix_flag_second,
  output logic double_err_flag_second,
  // Static configuration, tied at design time
  input wire logic ecc_on,
  input wire logic ecc_pipe_bypass,
  input wire logic wide12_all,
  input wire logic config_access_lock,
  // Configuration access interface
  input wire logic cai_req,
  input wire logic [`TPR_ADDR_W-1:0] cai_addr,
  output logic [`TPR_ROW_W-1:0] cai_rdata,
  output logic cai_busy
);

  localparam int NPORT = 2;

  // Both block-select bits must be high for a port to act.
  function automatic logic tpr_sel_hit(input logic [1:0] s);
    return s == `TPR_SEL_ALL;
  endfunction

  // Row of a wide pair: the low address bit is replaced by the half.
  function automatic logic [`TPR_ADDR_W-1:0] tpr_pair_row(
      input logic [`TPR_ADDR_W-1:0] a, input logic odd);
    return {a[`TPR_ADDR_W-1:1], odd};
  endfunction

  // The array is 128 rows of 12 bits; a wide word spans an even/odd pair.
  generate
    if (ADDR_W != `TPR_ADDR_W || DATA_W != `TPR_DATA_W ||
        ROW_W * 2 != `TPR_CODE_W ||
        ROW_W * `TPR_DEPTH != 1536) begin : g_chk
      $error("tpr_mem geometry not supported");
    end
  endgenerate

  logic [`TPR_ROW_W-1:0] mem [`TPR_DEPTH];  // R1

  // Write capture stage.
  tpr_pkg::tpr_wr_t wr_q;
  tpr_pkg::tpr_wr_t wr_in;

  assign wr_in.en = wr_en;
  assign wr_in.sel = wr_sel;
  assign wr_in.wide = wr_wide;
  assign wr_in.addr = wr_addr;
  assign wr_in.data = wr_data;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
    end else begin
      wr_q <= wr_in;  // R2 R8 R18
    end
  end

  // Write decode from the captured inputs.
  wire wr_go = wr_q.en && tpr_sel_hit(wr_q.sel);  // R17
  wire [`TPR_ADDR_W-1:0] wr_even = tpr_pair_row(wr_q.addr, 1'b0);
  wire [`TPR_ADDR_W-1:0] wr_odd = tpr_pair_row(wr_q.addr, 1'b1);
  wire [`TPR_CODE_W-1:0] wr_code = tpr_pkg::tpr_ecc_pack(wr_q.data);
  wire wr_pair = ecc_on || wr_q.wide;  // R6 R12
  wire [`TPR_ROW_W-1:0] wr_row_even = ecc_on ?
      wr_code[`TPR_ROW_W-1:0] :
      {mem[wr_even][`TPR_ROW_W-1:`TPR_NARROW_W],
       wr_q.data[`TPR_NARROW_W-1:0]};
  wire [`TPR_ROW_W-1:0] wr_row_odd = ecc_on ?
      wr_code[`TPR_CODE_W-1:`TPR_ROW_W] :
      {mem[wr_odd][`TPR_ROW_W-1:`TPR_NARROW_W],
       wr_q.data[`TPR_DATA_W-1:`TPR_NARROW_W]};
  wire [`TPR_ROW_W-1:0] wr_row_one = wide12_all ?
      wr_q.data[`TPR_ROW_W-1:0] :
      {mem[wr_q.addr][`TPR_ROW_W-1:`TPR_NARROW_W],
       wr_q.data[`TPR_NARROW_W-1:0]};

  // Collisions with reads are neither detected nor blocked; the write lands.
  always_ff @(posedge clk_sys) begin  // R10
    if (wr_go) begin  // R19
      if (wr_pair) begin
        mem[wr_even] <= wr_row_even;  // R14
        mem[wr_odd] <= wr_row_odd;
      end else begin
        mem[wr_q.addr] <= wr_row_one;  // R7
      end
    end
  end

  // Gather both read ports into carrier arrays.
  tpr_pkg::tpr_rd_ctl_t ctl [NPORT];
  tpr_pkg::tpr_rd_res_t res [NPORT];

  assign ctl[0].sel = rd_sel_first;
  assign ctl[0].addr = rd_addr_first;
  assign ctl[0].wide = rd_wide_first;
  assign ctl[0].areg_en = rd_areg_en_first;
  assign ctl[0].areg_sclr_n = rd_areg_sclr_first_n;
  assign ctl[0].areg_byp = rd_areg_bypass_first;
  assign ctl[0].pipe_en = rd_pipe_en_first;
  assign ctl[0].pipe_sclr_n = rd_pipe_sclr_first_n;
  assign ctl[0].pipe_byp = rd_pipe_bypass_first;
  assign ctl[1].sel = rd_sel_second;
  assign ctl[1].addr = rd_addr_second;
  assign ctl[1].wide = rd_wide_second;
  assign ctl[1].areg_en = rd_areg_en_second;
  assign ctl[1].areg_sclr_n = rd_areg_sclr_second_n;
  assign ctl[1].areg_byp = rd_areg_bypass_second;
  assign ctl[1].pipe_en = rd_pipe_en_second;
  assign ctl[1].pipe_sclr_n = rd_pipe_sclr_second_n;
  assign ctl[1].pipe_byp = rd_pipe_bypass_second;

  // The extra check stage only exists in pipelined check mode.
  wire ecc_stage_byp = !(ecc_on && !ecc_pipe_bypass);  // R22

  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_rd
      logic [`TPR_ADDR_W+1:0] areg_q;
      logic [1:0] sel_q;
      logic [`TPR_ADDR_W-1:0] addr_q;
      logic [`TPR_ROW_W-1:0] row_e;
      logic [`TPR_ROW_W-1:0] row_o;
      logic [`TPR_ROW_W-1:0] row_a;
      logic [`TPR_DATA_W-1:0] dec_data;
      logic dec_sb;
      logic dec_db;
      logic on;
      tpr_pkg::tpr_rd_res_t raw;
      tpr_pkg::tpr_rd_res_t ecc_q;
      tpr_pkg::tpr_rd_res_t pipe_q;

      // Block select travels with the address it qualifies.
      tpr_stage #(.W(`TPR_ADDR_W + 2)) u_areg (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .bypass(ctl[p].areg_byp),
        .en(ctl[p].areg_en),
        .sclr_n(ctl[p].areg_sclr_n),
        .d({ctl[p].sel, ctl[p].addr}),
        .q(areg_q)
      );  // R3

      assign sel_q = areg_q[`TPR_ADDR_W+1:`TPR_ADDR_W];
      assign addr_q = areg_q[`TPR_ADDR_W-1:0];
      assign row_e = mem[tpr_pair_row(addr_q, 1'b0)];  // R13
      assign row_o = mem[tpr_pair_row(addr_q, 1'b1)];
      assign row_a = mem[addr_q];  // R9

      tpr_ecc_dec u_dec (
        .code({row_o, row_e}),
        .data(dec_data),
        .sb(dec_sb),
        .db(dec_db)
      );

      assign on = tpr_sel_hit(sel_q);  // R16
      assign raw.sb = on && ecc_on && dec_sb;  // R11
      assign raw.db = on && ecc_on && dec_db;
      assign raw.data = !on ? '0 :
          ecc_on ? dec_data :
          ctl[p].wide ? {row_o[`TPR_NARROW_W-1:0],
                         row_e[`TPR_NARROW_W-1:0]} :
          wide12_all ? {6'h00, row_a} :
          {9'h000, row_a[`TPR_NARROW_W-1:0]};  // R15

      tpr_stage #(.W($bits(tpr_pkg::tpr_rd_res_t))) u_ereg (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .bypass(ecc_stage_byp),
        .en(1'b1),
        .sclr_n(1'b1),
        .d(raw),
        .q(ecc_q)
      );  // R25

      tpr_stage #(.W($bits(tpr_pkg::tpr_rd_res_t))) u_dreg (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .bypass(ctl[p].pipe_byp),
        .en(ctl[p].pipe_en),
        .sclr_n(ctl[p].pipe_sclr_n),
        .d(ecc_q),
        .q(pipe_q)
      );  // R4 R24

      assign res[p] = pipe_q;  // R5
    end
  endgenerate

  assign rd_data_first = res[0].data;
  assign single_fix_flag_first = res[0].sb;
  assign double_err_flag_first = res[0].db;
  assign rd_data_second = res[1].data;
  assign single_fix_flag_second = res[1].sb;
  assign double_err_flag_second = res[1].db;

  // Configuration access: one row read per request, refused while locked.
  wire cai_go = cai_req && !config_access_lock;  // R23

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cai_busy <= `TPR_RESET_VAL;
      cai_rdata <= '0;
    end else begin
      cai_busy <= cai_go;  // R23
      if (cai_go) begin
        cai_rdata <= mem[cai_addr];
      end
    end
  end

endmodule
`default_nettype wire

// ===== testbench/tpr_mem_chk.sv
// Concurrent checks on the ports of the three-port memory.
`default_nettype none
module tpr_mem_chk (
  // Clock and clear
  input wire logic clk_sys,
  input wire logic reset_n,
  // First read port
  input wire logic [1:0] rd_sel_first,
  input wire logic rd_wide_first,
  input wire logic rd_areg_bypass_first,
  input wire logic rd_pipe_en_first,
  input wire logic rd_pipe_sclr_first_n,
  input wire logic rd_pipe_bypass_first,
  input wire logic [17:0] rd_data_first,
  input wire logic single_fix_flag_first,
  input wire logic double_err_flag_first,
  // Second read port
  input wire logic [1:0] rd_sel_second,
  input wire logic rd_areg_bypass_second,
  input wire logic rd_pipe_bypass_second,
  input wire logic [17:0] rd_data_second,
  // Static configuration and access interface
  input wire logic ecc_on,
  input wire logic ecc_pipe_bypass,
  input wire logic wide12_all,
  input wire logic config_access_lock,
  input wire logic cai_req,
  input wire logic cai_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_desel_first: assert property (rd_areg_bypass_first &&
    (!ecc_on || ecc_pipe_bypass) &&
    rd_pipe_bypass_first && rd_sel_first != 2'h3 |-> rd_data_first == '0)
    else $error("first port not zero while deselected");
  a_desel_second: assert property (rd_areg_bypass_second &&
    (!ecc_on || ecc_pipe_bypass) &&
    rd_pipe_bypass_second && rd_sel_second != 2'h3 |-> rd_data_second == '0)
    else $error("second port not zero while deselected");
  a_desel_ecc_first: assert property (ecc_on && !ecc_pipe_bypass &&
    rd_areg_bypass_first && rd_pipe_bypass_first && rd_sel_first != 2'h3
    |=> rd_data_first == '0)
    else $error("first port not zero after deselect with checking");
  a_desel_ecc_second: assert property (ecc_on && !ecc_pipe_bypass &&
    rd_areg_bypass_second && rd_pipe_bypass_second && rd_sel_second != 2'h3
    |=> rd_data_second == '0)
    else $error("second port not zero after deselect with checking");
  a_narrow_upper_zero: assert property (rd_areg_bypass_first &&
    rd_pipe_bypass_first && !ecc_on && !wide12_all && !rd_wide_first
    |-> rd_data_first[17:9] == 9'h000)
    else $error("upper bits set in narrow read");
  a_sclr_clears: assert property (rd_pipe_en_first &&
    !rd_pipe_sclr_first_n && !rd_pipe_bypass_first |=> rd_data_first == '0
    && !single_fix_flag_first && !double_err_flag_first)
    else $error("synchronous clear did not zero the read stage");
  a_pipe_holds: assert property (!rd_pipe_bypass_first &&
    !rd_pipe_en_first |=> rd_pipe_bypass_first || $stable(rd_data_first))
    else $error("disabled read stage changed");
  a_lock_idle: assert property (config_access_lock |=> !cai_busy)
    else $error("busy raised while locked");
  a_busy_pulse: assert property (!config_access_lock && cai_req
    |=> cai_busy) else $error("busy missing after access");
  a_busy_cause: assert property (cai_busy |-> $past(cai_req) &&
    !$past(config_access_lock)) else $error("busy without a request");
  a_flags_quiet: assert property (!ecc_on |->
    !single_fix_flag_first && !double_err_flag_first)
    else $error("flag raised with checking off");
endmodule

bind tpr_mem tpr_mem_chk tpr_mem_chk_i (.clk_sys, .reset_n, .rd_sel_first,
  .rd_wide_first, .rd_areg_bypass_first, .rd_pipe_en_first,
  .rd_pipe_sclr_first_n, .rd_pipe_bypass_first, .rd_data_first,
  .single_fix_flag_first, .double_err_flag_first, .rd_sel_second,
  .rd_areg_bypass_second, .rd_pipe_bypass_second, .rd_data_second,
  .ecc_on, .ecc_pipe_bypass, .wide12_all, .config_access_lock, .cai_req,
  .cai_busy);
`default_nettype wire

// ===== testbench/tpr_fab.sv
// Fabric model that drives the write port of the three-port memory.
`default_nettype none
module tpr_fab (
  // Clock
  input wire logic clk_sys,
  // Write port
  output var tpr_pkg::tpr_wr_t wr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial wr = '0;
  // Released data shows its inverse so a stale word is never mistaken.
  task automatic put(input logic [6:0] a, input logic [17:0] d,
      input logic e, input logic [1:0] s, input logic w);
    @(posedge clk_sys);
    wr <= '{en: e, sel: s, wide: w, addr: a, data: d};
    @(posedge clk_sys);
    wr.en <= 1'h0;
    wr.sel <= 2'h0;
    wr.data <= ~d;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_tpr_mem.sv
// Self-checking bench for the three-port memory.
`default_nettype none
module tb_tpr_mem;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset_n, lock, req;
  tpr_pkg::tpr_rd_ctl_t r1, r2;
  tpr_pkg::tpr_wr_t wr;
  logic [17:0] q1, q2;
  logic sb1, db1, sb2, db2, busy;
  logic [17:0] qe;
  logic [11:0] row;
  logic sbe, dbe;
  int error_cnt, checks_done, cyc;
  tpr_fab tpr_fab_i (.clk_sys, .wr);
  tpr_mem tpr_mem_i (.clk_sys, .reset_n, .wr_addr(wr.addr),
    .wr_data(wr.data), .wr_en(wr.en), .wr_sel(wr.sel), .wr_wide(wr.wide),
    .rd_addr_first(r1.addr), .rd_sel_first(r1.sel), .rd_wide_first(r1.wide),
    .rd_areg_en_first(r1.areg_en), .rd_areg_sclr_first_n(r1.areg_sclr_n),
    .rd_areg_bypass_first(r1.areg_byp), .rd_pipe_en_first(r1.pipe_en),
    .rd_pipe_sclr_first_n(r1.pipe_sclr_n), .rd_pipe_bypass_first(r1.pipe_byp),
    .rd_data_first(q1), .single_fix_flag_first(sb1),
    .double_err_flag_first(db1), .rd_addr_second(r2.addr),
    .rd_sel_second(r2.sel), .rd_wide_second(r2.wide),
    .rd_areg_en_second(r2.areg_en), .rd_areg_sclr_second_n(r2.areg_sclr_n),
    .rd_areg_bypass_second(r2.areg_byp), .rd_pipe_en_second(r2.pipe_en),
    .rd_pipe_sclr_second_n(r2.pipe_sclr_n),
    .rd_pipe_bypass_second(r2.pipe_byp), .rd_data_second(q2),
    .single_fix_flag_second(sb2), .double_err_flag_second(db2),
    .ecc_on(1'h0), .ecc_pipe_bypass(1'h1), .wide12_all(1'h0),
    .config_access_lock(lock), .cai_req(req), .cai_addr(7'h00),
    .cai_rdata(row), .cai_busy(busy));

  // A copy with pipelined checking shares the stimulus of the plain one.
  if (1) begin : g_ecc
    tpr_mem tpr_mem_i (.clk_sys, .reset_n, .wr_addr(wr.addr),
      .wr_data(wr.data), .wr_en(wr.en), .wr_sel(wr.sel), .wr_wide(wr.wide),
      .rd_addr_first(r1.addr), .rd_sel_first(r1.sel),
      .rd_wide_first(r1.wide), .rd_areg_en_first(r1.areg_en),
      .rd_areg_sclr_first_n(r1.areg_sclr_n),
      .rd_areg_bypass_first(r1.areg_byp), .rd_pipe_en_first(r1.pipe_en),
      .rd_pipe_sclr_first_n(r1.pipe_sclr_n),
      .rd_pipe_bypass_first(r1.pipe_byp), .rd_data_first(qe),
      .single_fix_flag_first(sbe), .double_err_flag_first(dbe),
      .rd_addr_second(r2.addr), .rd_sel_second(r2.sel),
      .rd_wide_second(r2.wide), .rd_areg_en_second(r2.areg_en),
      .rd_areg_sclr_second_n(r2.areg_sclr_n),
      .rd_areg_bypass_second(r2.areg_byp), .rd_pipe_en_second(r2.pipe_en),
      .rd_pipe_sclr_second_n(r2.pipe_sclr_n),
      .rd_pipe_bypass_second(r2.pipe_byp), .rd_data_second(),
      .single_fix_flag_second(), .double_err_flag_second(),
      .ecc_on(1'h1), .ecc_pipe_bypass(1'h0), .wide12_all(1'h0),
      .config_access_lock(lock), .cai_req(req), .cai_addr(7'h00),
      .cai_rdata(), .cai_busy());
  end

  task automatic chk(input string n, input logic [17:0] e, s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Present an address on the first port, wait the edges, then settle.
  task automatic rd(input logic [6:0] a, input logic w, input int lat);
    @(posedge clk_sys);
    r1.addr <= a;
    r1.wide <= w;
    repeat (lat) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    reset_n = 1'h0;
    lock = 1'h1;
    req = 1'h0;
    r1 = '{sel: 2'h3, areg_en: 1'h1, areg_sclr_n: 1'h1, areg_byp: 1'h1,
      pipe_en: 1'h1, pipe_sclr_n: 1'h1, pipe_byp: 1'h1, default: '0};
    r2 = r1;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'h1;
    tpr_fab_i.put(7'h00, 18'h0015A, 1'h1, 2'h3, 1'h0);
    tpr_fab_i.put(7'h7F, 18'h001C3, 1'h1, 2'h3, 1'h0);
    rd(7'h00, 1'h0, 0);
    chk("narrow low", 18'h0015A, q1);
    tpr_fab_i.put(7'h7F, 18'h00055, 1'h0, 2'h3, 1'h0);
    tpr_fab_i.put(7'h7F, 18'h00055, 1'h1, 2'h1, 1'h0);
    rd(7'h7F, 1'h0, 0);
    chk("refused write", 18'h001C3, q1);
    $display("test narrow done");
    tpr_fab_i.put(7'h20, 18'h2A5C3, 1'h1, 2'h3, 1'h1);
    tpr_fab_i.put(7'h22, 18'h1B34E, 1'h1, 2'h3, 1'h1);
    r2.addr <= 7'h20;
    r2.wide <= 1'h1;
    rd(7'h20, 1'h1, 0);
    chk("wide first", 18'h2A5C3, q1);
    chk("wide second", 18'h2A5C3, q2);
    rd(7'h20, 1'h0, 0);
    chk("even half", 18'h001C3, q1);
    rd(7'h21, 1'h0, 0);
    chk("odd half", 18'h00152, q1);
    @(posedge clk_sys);
    r1.sel <= 2'h2;
    r2.sel <= 2'h1;
    #1;
    chk("deselect first", 18'h00000, q1);
    chk("deselect second", 18'h00000, q2);
    @(posedge clk_sys);
    r1.sel <= 2'h3;
    r2.sel <= 2'h3;
    $display("test wide done");
    for (int m = 0; m < 4; m++) begin
      int n;
      n = 2 - m[0] - m[1];
      @(posedge clk_sys);
      r1.areg_byp <= m[0];
      r1.pipe_byp <= m[1];
      rd(7'h20, 1'h1, 3);
      rd(7'h22, 1'h1, 0);
      for (int k = 0; k < n; k++) begin
        chk("early data", 18'h2A5C3, q1);
        @(posedge clk_sys);
        #1;
      end
      chk("mode latency", 18'h1B34E, q1);
      chk("check stage early", 18'h2A5C3, qe);
      @(posedge clk_sys);
      #1;
      chk("check stage late", 18'h1B34E, qe);
    end
    $display("test modes done");
    @(posedge clk_sys);
    r1.pipe_byp <= 1'h0;
    r1.pipe_sclr_n <= 1'h0;
    @(posedge clk_sys);
    r1.pipe_sclr_n <= 1'h1;
    r1.pipe_en <= 1'h0;
    #1;
    chk("sync clear", 18'h00000, q1);
    rd(7'h20, 1'h1, 2);
    chk("stage hold", 18'h00000, q1);
    @(posedge clk_sys);
    r1.pipe_en <= 1'h1;
    @(posedge clk_sys);
    #1;
    chk("stage load", 18'h2A5C3, q1);
    $display("test stage done");
    @(posedge clk_sys);
    req <= 1'h1;
    @(posedge clk_sys);
    lock <= 1'h0;
    #1;
    chk("locked busy", 18'h00000, {17'h0, busy});
    @(posedge clk_sys);
    req <= 1'h0;
    #1;
    chk("access busy", 18'h00001, {17'h0, busy});
    chk("access row", 18'h0015A, {9'h000, row[8:0]});
    chk("flags", 18'h00000, {12'h0, sb1, db1, sb2, db2, sbe, dbe});
    $display("test access done");
    wrap_up();
  end
endmodule
`default_nettype wire
